// *** design/bptd_pkg.sv ***
// constants, register map and types shared by the debug unit files
package bptd_pkg;

	// ****************************************
	// widths and depths
	// ****************************************
	localparam int ADDR_W = 16; // cpu address width
	localparam int DATA_W = 8; // cpu data width
	localparam int WB_W = 32; // wishbone data width
	localparam int WB_AW = 8; // wishbone byte address width
	localparam int FIFO_DEPTH = 8; // trace fifo stages
	localparam int CNT_W = 4; // fifo word count width

	// ****************************************
	// register byte offsets
	// ****************************************
	localparam logic [7:0] OFS_CTRL = 8'h00; // debug_status_control
	localparam logic [7:0] OFS_BKPT = 8'h04; // breakpoint_match_address
	localparam logic [7:0] OFS_CMPA = 8'h08; // comparator a value
	localparam logic [7:0] OFS_CMPB = 8'h0C; // comparator b value
	localparam logic [7:0] OFS_FIFOH = 8'h10; // trace_fifo_high_byte
	localparam logic [7:0] OFS_FIFOL = 8'h14; // trace_fifo_low_byte, read shifts
	localparam logic [7:0] OFS_STAT = 8'h18; // run status

	// ****************************************
	// control register fields
	// ****************************************
	localparam int CTL_BKEN = 0; // simple_breakpoint_enable
	localparam int CTL_FTS = 1; // force_tag_select, 1 forced
	localparam int CTL_ARM = 2; // arm a trace run
	localparam int CTL_BRKEN = 3; // trace trigger breaks the cpu
	localparam int CTL_TAG = 4; // trace break is tag type
	localparam int CTL_TRGSEL = 5; // opcode tracking on comparators
	localparam int CTL_BEGIN = 6; // begin type trace
	localparam int CTL_MODE_LO = 8; // trigger mode low bit
	localparam int CTL_MODE_HI = 11; // trigger mode high bit
	localparam int CTL_RW_QUALIFY_ENABLE_A = 12; // rw_qualify_enable_a
	localparam int CTL_RWA = 13; // rw_match_value_a
	localparam int CTL_RWBEN = 14; // rw qualify enable b
	localparam int CTL_RWB = 15; // rw match value b
	localparam logic [15:0] CTRL_RST = 16'h0000; // everything off

	// ****************************************
	// status register fields
	// ****************************************
	localparam int STA_ARMF = 0; // run armed
	localparam int STA_AF = 1; // comparator a matched
	localparam int STA_BF = 2; // comparator b matched
	localparam int STA_CNT_LO = 8; // fifo_word_count low bit

	// ****************************************
	// trigger modes
	// ****************************************
	localparam logic [3:0] MODE_A_ONLY = 4'h0;
	localparam logic [3:0] MODE_A_OR_B = 4'h1;
	localparam logic [3:0] MODE_A_THEN_B = 4'h2;
	localparam logic [3:0] MODE_EVT_B = 4'h3;
	localparam logic [3:0] MODE_A_THEN_EVT_B = 4'h4;
	localparam logic [3:0] MODE_A_AND_D = 4'h5;
	localparam logic [3:0] MODE_A_NOT_D = 4'h6;
	localparam logic [3:0] MODE_INSIDE = 4'h7;
	localparam logic [3:0] MODE_OUTSIDE = 4'h8;

	// ****************************************
	// change-of-flow kinds from the cpu
	// ****************************************
	localparam logic [1:0] COF_COND = 2'h0; // taken conditional branch
	localparam logic [1:0] COF_UNCOND = 2'h1; // unconditional_jump_op or never_taken_op
	localparam logic [1:0] COF_INDIR = 2'h2; // indirect jump_instr or subroutine_call_instr
	localparam logic [1:0] COF_INTRET = 2'h3; // interrupt or return

	// ****************************************
	// counts
	// ****************************************
	localparam logic [1:0] COF_BLANK = 2'h2; // cycles dropped after begin trigger
	localparam logic [3:0] CNT_FULL = 4'h8; // full fifo count
	localparam logic [3:0] CNT_LAST = 4'h7; // one below full
	localparam logic [3:0] CNT_ONE = 4'h1; // count step

	// run state
	typedef enum logic [3:0] {
		ST_IDLE = 4'b0001,
		ST_WAIT = 4'b0010,
		ST_STORE = 4'b0100,
		ST_DRAIN = 4'b1000
	} bptd_state_t;

endpackage

// *** design/bptd_fifo_mem.sv ***
// eight stage shifting word store for the trace fifo
`timescale 1ns/100ps
module bptd_fifo_mem (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic shift,
	input wire logic [bptd_pkg::ADDR_W-1:0] din,
	output logic [bptd_pkg::ADDR_W-1:0] dout
);

	// the stages, newest at index 0
	logic [bptd_pkg::ADDR_W-1:0] stage [bptd_pkg::FIFO_DEPTH];

	// ****************************************
	// shift chain
	// ****************************************
	genvar g;
	for (g = 0; g < bptd_pkg::FIFO_DEPTH; g++) begin : gen_stage
		// each stage takes its upstream neighbour on a shift
		always_ff @(posedge ref_clk or negedge rst_n) begin
			if (!rst_n) begin
				stage[g] <= '0;
			end else if (shift) begin
				stage[g] <= (g == 0) ? din : stage[(g == 0) ? 0 : g - 1];
			end
		end
	end

	// registered data port shows the oldest stage
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			dout <= '0;
		end else begin
			dout <= stage[bptd_pkg::FIFO_DEPTH-1];
		end
	end

endmodule

// *** design/bptd_unit.sv ***
// breakpoint and bus trace debug unit with wishbone register access
// How it works
// - simple breakpoint compares address to match register
// - forced type: any access to address breaks
// - tagged type: mark opcode fetched at address
// - breakpoint enable resets zero, gates simple breakpoint requests only
// - select bit one forced, zero tagged
// - eight stage fifo stores address or data
// - two comparators, each optional rw qualify
// - opcode tracking triggers only on execution
// - comparators also do range magnitude compares
// - debug controller accesses never match comparators
// - a compares address, b address or data
// - write data bus when a qualified write
// - match breaks, stores data, begins or ends
// - word count tracks stores; manual halt shifts once unless empty or full
// - low byte read shifts fifo forward
// - event modes store data byte, high unused
// - flow changes near begin trigger are dropped
// - end trigger flow change stored as last
// - unarmed low read pushes last opcode address
// - branch source, indirect and return destinations
//
// Decided for this implementation: the placing of the registers and the Wishbone register port.
`timescale 1ns/100ps
module bptd_unit (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [bptd_pkg::WB_AW-1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [bptd_pkg::WB_W-1:0] wb_dat_i,
	output logic [bptd_pkg::WB_W-1:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic cpu_valid,
	input wire logic [bptd_pkg::ADDR_W-1:0] cpu_addr,
	input wire logic cpu_rw,
	input wire logic [bptd_pkg::DATA_W-1:0] cpu_rdata,
	input wire logic [bptd_pkg::DATA_W-1:0] cpu_wdata,
	input wire logic cpu_opfetch,
	input wire logic cpu_exec,
	input wire logic [bptd_pkg::ADDR_W-1:0] cpu_exec_addr,
	input wire logic cpu_flush,
	input wire logic bdc_access,
	input wire logic cof_valid,
	input wire logic [1:0] cof_kind,
	input wire logic [bptd_pkg::ADDR_W-1:0] cof_src,
	input wire logic [bptd_pkg::ADDR_W-1:0] cof_dst,
	output logic cpu_break_force,
	output logic cpu_break_tag
);

	// ****************************************
	// functions
	// ****************************************

	// rw qualifier passes when disabled or rw equals wanted value
	function automatic logic rw_ok(input logic en, input logic val, input logic rw);
		return ~en | (rw == val);
	endfunction

	// expand byte selects to a bit mask
	function automatic logic [31:0] byte_mask(input logic [3:0] sel);
		return {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
	endfunction

	// merge a write into a 16 bit register under the byte mask
	function automatic logic [15:0] merge16(input logic [15:0] old,
		input logic [31:0] d, input logic [31:0] m);
		return (old & ~m[15:0]) | (d[15:0] & m[15:0]);
	endfunction

	// ****************************************
	// state
	// ****************************************
	logic [15:0] ctrl; // debug_status_control
	logic [15:0] bkpt_addr; // breakpoint_match_address
	logic [15:0] cmp_a; // comparator a value
	logic [15:0] cmp_b; // comparator b value
	logic af; // comparator a seen
	logic bf; // comparator b seen
	logic [3:0] cnt; // fifo_word_count
	logic a_seen; // a matched, for then modes
	logic [1:0] blank; // begin blanking counter
	logic [1:0] pv; // cof pipe valid
	logic [15:0] pa0; // cof pipe stage 0
	logic [15:0] pa1; // cof pipe stage 1
	logic [15:0] last_op; // most recent opcode fetch address
	logic [1:0] pend; // opcode tracking flags
	logic [15:0] fifo_q; // fifo data port
	bptd_pkg::bptd_state_t state; // run state
	bptd_pkg::bptd_state_t next_state; // next run state

	// ****************************************
	// wishbone decode
	// ****************************************
	wire wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o; // waiting for ack
	wire wb_fire = wb_cyc_i & wb_stb_i & wb_ack_o; // completing edge
	wire wr_fire = wb_fire & wb_we_i;
	wire rd_fire = wb_fire & ~wb_we_i;
	wire [31:0] wmask = byte_mask(wb_sel_i);
	wire sel_ctrl = wb_adr_i == bptd_pkg::OFS_CTRL;
	wire sel_bkpt = wb_adr_i == bptd_pkg::OFS_BKPT;
	wire sel_cmpa = wb_adr_i == bptd_pkg::OFS_CMPA;
	wire sel_cmpb = wb_adr_i == bptd_pkg::OFS_CMPB;
	wire sel_fifoh = wb_adr_i == bptd_pkg::OFS_FIFOH;
	wire sel_fifol = wb_adr_i == bptd_pkg::OFS_FIFOL;
	wire sel_stat = wb_adr_i == bptd_pkg::OFS_STAT;
	wire [15:0] new_ctrl = merge16(ctrl, wb_dat_i, wmask);
	wire ctrl_wr = wr_fire & sel_ctrl;
	wire rd_low = rd_fire & sel_fifol;

	// status word
	wire [15:0] stat_word = (16'(cnt) << bptd_pkg::STA_CNT_LO)
		| (16'(bf) << bptd_pkg::STA_BF) | (16'(af) << bptd_pkg::STA_AF)
		| (16'(ctrl[bptd_pkg::CTL_ARM]) << bptd_pkg::STA_ARMF);

	// read mux, unmapped reads give zero
	wire [15:0] rd_data = sel_ctrl ? ctrl : sel_bkpt ? bkpt_addr
		: sel_cmpa ? cmp_a : sel_cmpb ? cmp_b
		: sel_fifoh ? {8'h00, fifo_q[15:8]} : sel_fifol ? {8'h00, fifo_q[7:0]}
		: sel_stat ? stat_word : 16'h0000;

	// ****************************************
	// control fields
	// ****************************************
	wire arm = ctrl[bptd_pkg::CTL_ARM];
	wire bk_en = ctrl[bptd_pkg::CTL_BKEN];
	wire force_tag_select = ctrl[bptd_pkg::CTL_FTS];
	wire brk_en = ctrl[bptd_pkg::CTL_BRKEN];
	wire tag_sel = ctrl[bptd_pkg::CTL_TAG];
	wire trgsel = ctrl[bptd_pkg::CTL_TRGSEL];
	wire rw_qualify_enable_a = ctrl[bptd_pkg::CTL_RW_QUALIFY_ENABLE_A];
	wire rw_match_value_a = ctrl[bptd_pkg::CTL_RWA];
	wire [3:0] mode = ctrl[bptd_pkg::CTL_MODE_HI:bptd_pkg::CTL_MODE_LO];
	wire [3:0] new_mode = new_ctrl[bptd_pkg::CTL_MODE_HI:bptd_pkg::CTL_MODE_LO];
	wire is_event = (mode == bptd_pkg::MODE_EVT_B) | (mode == bptd_pkg::MODE_A_THEN_EVT_B);
	wire new_event = (new_mode == bptd_pkg::MODE_EVT_B)
		| (new_mode == bptd_pkg::MODE_A_THEN_EVT_B);
	wire is_full = (mode == bptd_pkg::MODE_A_AND_D) | (mode == bptd_pkg::MODE_A_NOT_D);
	wire begin_type = ctrl[bptd_pkg::CTL_BEGIN] | is_event; // event runs are begin type
	wire arm_start = ctrl_wr & new_ctrl[bptd_pkg::CTL_ARM];
	wire arm_stop = ctrl_wr & ~new_ctrl[bptd_pkg::CTL_ARM] & arm;

	// ****************************************
	// simple breakpoint
	// ****************************************
	wire sb_hit = bk_en & cpu_valid & (cpu_addr == bkpt_addr);
	wire sb_force = sb_hit & force_tag_select;
	wire sb_tag = sb_hit & ~force_tag_select & cpu_opfetch;

	// ****************************************
	// comparators
	// ****************************************
	wire bus_ok = cpu_valid & ~bdc_access;
	wire rw_a = rw_ok(rw_qualify_enable_a, rw_match_value_a, cpu_rw);
	wire rw_b = rw_ok(ctrl[bptd_pkg::CTL_RWBEN], ctrl[bptd_pkg::CTL_RWB], cpu_rw);
	wire [7:0] data_sel = (rw_qualify_enable_a & ~rw_match_value_a) ? cpu_wdata : cpu_rdata;
	wire a_eq = cpu_addr == cmp_a;
	wire b_eq = cpu_addr == cmp_b;
	wire d_eq = data_sel == cmp_b[7:0];
	wire a_raw = bus_ok & a_eq & rw_a;
	wire b_raw = bus_ok & b_eq & rw_b;
	wire in_rng = bus_ok & rw_a & (cpu_addr >= cmp_a) & (cpu_addr <= cmp_b);
	wire out_rng = bus_ok & rw_a & ((cpu_addr < cmp_a) | (cpu_addr > cmp_b));

	// opcode tracking, one tracker per comparator
	wire [1:0] fetch_hit = {bus_ok & cpu_opfetch & b_eq, bus_ok & cpu_opfetch & a_eq};
	wire [1:0] exec_hit = {cpu_exec & (cpu_exec_addr == cmp_b),
		cpu_exec & (cpu_exec_addr == cmp_a)};
	wire [1:0] trk;
	genvar g;
	for (g = 0; g < 2; g++) begin : gen_track
		// pending while a matched opcode sits in the queue
		always_ff @(posedge ref_clk or negedge rst_n) begin
			if (!rst_n) begin
				pend[g] <= 1'b0;
			end else if (cpu_flush | exec_hit[g]) begin
				pend[g] <= 1'b0;
			end else if (fetch_hit[g]) begin
				pend[g] <= 1'b1;
			end
		end
		assign trk[g] = pend[g] & exec_hit[g] & ~cpu_flush;
	end
	wire a_q = trgsel ? trk[0] : a_raw;
	wire b_q = trgsel ? trk[1] : b_raw;

	// trigger per mode
	wire trig_mode = (mode == bptd_pkg::MODE_A_ONLY) ? a_q
		: (mode == bptd_pkg::MODE_A_OR_B) ? (a_q | b_q)
		: (mode == bptd_pkg::MODE_A_THEN_B) ? (a_seen & b_q)
		: (mode == bptd_pkg::MODE_EVT_B) ? b_q
		: (mode == bptd_pkg::MODE_A_THEN_EVT_B) ? (a_seen & b_q)
		: (mode == bptd_pkg::MODE_A_AND_D) ? (a_q & d_eq)
		: (mode == bptd_pkg::MODE_A_NOT_D) ? (a_q & ~d_eq)
		: (mode == bptd_pkg::MODE_INSIDE) ? in_rng
		: (mode == bptd_pkg::MODE_OUTSIDE) ? out_rng : 1'b0;
	wire running = (state == bptd_pkg::ST_WAIT) | (state == bptd_pkg::ST_STORE);
	wire trig = running & trig_mode;

	// trace breakpoint; full modes tag on the address match only
	wire tr_force = brk_en & ~tag_sel & trig;
	wire tr_tag = brk_en & tag_sel & cpu_opfetch & running & (is_full ? a_q : trig_mode);

	// ****************************************
	// change of flow and fifo input
	// ****************************************
	wire cof_keep = (cof_kind != bptd_pkg::COF_UNCOND);
	wire [15:0] cof_pick = (cof_kind == bptd_pkg::COF_COND) ? cof_src : cof_dst;
	wire cof_take = cof_valid & cof_keep & ~is_event
		& (state == bptd_pkg::ST_STORE) & (blank == 2'b00);
	wire store_on = (state == bptd_pkg::ST_STORE) | (state == bptd_pkg::ST_DRAIN);
	wire push_cof = pv[1] & store_on & ~is_event;
	wire push_evt = (state == bptd_pkg::ST_STORE) & is_event & trig;
	wire push = push_cof | push_evt;
	wire [15:0] push_word = push_evt ? {8'h00, data_sel} : pa1;
	wire prof = rd_low & ~arm;
	wire halt_shift = arm_stop & (cnt != 4'h0) & (cnt != bptd_pkg::CNT_FULL);
	wire mem_shift = push | rd_low | halt_shift;
	wire [15:0] mem_din = push ? push_word : prof ? last_op : 16'h0000;
	wire fill_end = push & begin_type & (cnt == bptd_pkg::CNT_LAST);
	wire begin_go = (state == bptd_pkg::ST_WAIT) & trig;
	wire cnt_inc = (push | prof) & (cnt != bptd_pkg::CNT_FULL);

	// ****************************************
	// run state machine
	// ****************************************
	always_comb begin
		next_state = state;
		unique case (state)
			bptd_pkg::ST_IDLE: begin
				next_state = bptd_pkg::ST_IDLE;
			end
			bptd_pkg::ST_WAIT: begin
				if (begin_go) begin
					next_state = bptd_pkg::ST_STORE;
				end
			end
			bptd_pkg::ST_STORE: begin
				if (fill_end) begin
					next_state = bptd_pkg::ST_IDLE;
				end else if (~begin_type & trig) begin
					next_state = bptd_pkg::ST_DRAIN;
				end
			end
			bptd_pkg::ST_DRAIN: begin
				if (pv == 2'b00) begin
					next_state = bptd_pkg::ST_IDLE;
				end
			end
		endcase
		if (arm_stop) begin
			next_state = bptd_pkg::ST_IDLE;
		end
		if (arm_start) begin
			next_state = (new_ctrl[bptd_pkg::CTL_BEGIN] & ~new_event)
				? bptd_pkg::ST_WAIT : bptd_pkg::ST_STORE;
		end
	end

	// state register
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= bptd_pkg::ST_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// ****************************************
	// registers written by software
	// ****************************************

	// control, arm drops when a run ends on its own
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl <= bptd_pkg::CTRL_RST;
		end else if (ctrl_wr) begin
			ctrl <= new_ctrl;
		end else if (next_state == bptd_pkg::ST_IDLE) begin
			ctrl[bptd_pkg::CTL_ARM] <= 1'b0;
		end
	end

	// match values
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			bkpt_addr <= 16'h0000;
			cmp_a <= 16'h0000;
			cmp_b <= 16'h0000;
		end else if (wr_fire) begin
			if (sel_bkpt) begin
				bkpt_addr <= merge16(bkpt_addr, wb_dat_i, wmask);
			end
			if (sel_cmpa) begin
				cmp_a <= merge16(cmp_a, wb_dat_i, wmask);
			end
			if (sel_cmpb) begin
				cmp_b <= merge16(cmp_b, wb_dat_i, wmask);
			end
		end
	end

	// ****************************************
	// run bookkeeping
	// ****************************************

	// flags and word count; arming clears and wins over sets
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			af <= 1'b0;
			bf <= 1'b0;
			a_seen <= 1'b0;
			cnt <= 4'h0;
		end else begin
			if (arm_start) begin
				af <= 1'b0;
				bf <= 1'b0;
				a_seen <= 1'b0;
				cnt <= 4'h0;
			end else begin
				af <= af | (running & a_q);
				bf <= bf | (running & b_q);
				a_seen <= a_seen | (running & a_q);
				if (cnt_inc) begin
					cnt <= cnt + bptd_pkg::CNT_ONE;
				end
			end
		end
	end

	// blanking after begin trigger and the two stage cof pipe
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			blank <= 2'b00;
			pv <= 2'b00;
			pa0 <= 16'h0000;
			pa1 <= 16'h0000;
		end else begin
			blank <= begin_go ? bptd_pkg::COF_BLANK : (blank != 2'b00) ? blank - 2'b01 : blank;
			pv <= {pv[0] & ~arm_start, cof_take};
			pa0 <= cof_pick;
			pa1 <= pa0;
		end
	end

	// most recent opcode fetch address for profiling
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			last_op <= 16'h0000;
		end else if (cpu_valid & cpu_opfetch) begin
			last_op <= cpu_addr;
		end
	end

	// trace fifo storage
	bptd_fifo_mem u_mem (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.shift(mem_shift),
		.din(mem_din),
		.dout(fifo_q)
	);

	// ****************************************
	// outputs
	// ****************************************

	// wishbone answer one cycle after the request
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= '0;
		end else begin
			wb_ack_o <= wb_req;
			if (wb_req) begin
				wb_dat_o <= {16'h0000, rd_data};
			end
		end
	end

	// break requests to the cpu
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			cpu_break_force <= 1'b0;
			cpu_break_tag <= 1'b0;
		end else begin
			cpu_break_force <= sb_force | tr_force;
			cpu_break_tag <= sb_tag | tr_tag;
		end
	end

endmodule

// *** verification/bptd_cpu_model.sv ***
// behavioural cpu core that drives bus cycles into the debug unit
`timescale 1ns/100ps
module bptd_cpu_model (
	input wire logic ref_clk,
	output logic cpu_valid,
	output logic [15:0] cpu_addr,
	output logic cpu_rw,
	output logic [7:0] cpu_rdata,
	output logic [7:0] cpu_wdata,
	output logic cpu_opfetch,
	output logic bdc_access,
	output logic [15:0] cpu_exec_addr,
	output logic [15:0] cof_src,
	output logic [15:0] cof_dst
);
	// ****************************************
	// side buses follow the address bus
	// ****************************************
	assign cpu_exec_addr = cpu_addr;
	assign cof_src = cpu_addr;
	assign cof_dst = ~cpu_addr;
	// idle bus at time zero
	initial begin
		{cpu_valid, cpu_rw, cpu_opfetch, bdc_access} = 4'h0;
		{cpu_addr, cpu_rdata, cpu_wdata} = 32'h0;
	end
	// one bus cycle; write data is the inverse of read data
	task automatic cycle(input logic [15:0] a, input logic rw, input logic [7:0] d,
		input logic fetch, input logic bdc);
		@(posedge ref_clk);
		cpu_valid <= 1'b1;
		cpu_addr <= a;
		cpu_rw <= rw;
		cpu_rdata <= d;
		cpu_wdata <= ~d;
		cpu_opfetch <= fetch;
		bdc_access <= bdc;
		@(posedge ref_clk);
		// strobes, address and read data change; rw and write data keep the last value
		{cpu_valid, cpu_opfetch, bdc_access} <= 3'h0;
		cpu_addr <= ~a;
		cpu_rdata <= d + 8'h5B;
	endtask
endmodule

// *** verification/bptd_unit_assertions.sv ***
// concurrent checks on the ports of the debug unit
`timescale 1ns/100ps
module bptd_unit_chk (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic wb_ack_o,
	input wire logic [31:0] wb_dat_o,
	input wire logic cpu_valid,
	input wire logic cpu_opfetch,
	input wire logic cpu_exec,
	input wire logic cpu_break_force,
	input wire logic cpu_break_tag
);
	logic ctrl_seen; // control written since reset
	// ****************************************
	// helper: first control write
	// ****************************************
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_seen <= 1'b0;
		end else if (wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_adr_i == 8'h00) begin
			ctrl_seen <= 1'b1;
		end
	end
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	// read request to an unmapped place
	sequence rd_unmapped;
		wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o && wb_adr_i > 8'h18;
	endsequence
	ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("request not answered");
	ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
		else $error("ack without request");
	data_hold_a: assert property (!wb_ack_o |-> $stable(wb_dat_o))
		else $error("read data moved between answers");
	data_upper_a: assert property (wb_dat_o[31:16] == 16'h0000)
		else $error("upper read data not zero");
	unmapped_zero_a: assert property (rd_unmapped |=> wb_ack_o && wb_dat_o == 32'h0)
		else $error("unmapped read not zero");
	force_cause_a: assert property (cpu_break_force |-> $past(cpu_valid || cpu_exec))
		else $error("force break without bus cycle");
	tag_cause_a: assert property (cpu_break_tag |-> $past(cpu_opfetch || cpu_exec))
		else $error("tag break without fetch");
	break_off_a: assert property (!ctrl_seen |-> !cpu_break_force && !cpu_break_tag)
		else $error("break before enable");
endmodule
bind bptd_unit bptd_unit_chk chk (.ref_clk, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i,
	.wb_adr_i, .wb_ack_o, .wb_dat_o, .cpu_valid, .cpu_opfetch, .cpu_exec,
	.cpu_break_force, .cpu_break_tag);

// *** verification/testbench.sv ***
// self-checking bench for the breakpoint and trace debug unit
`timescale 1ns/100ps
module testbench;
	logic ref_clk, rst_n, wb_cyc_i, wb_stb_i, wb_we_i; // bus master side
	logic [7:0] wb_adr_i;
	logic [3:0] wb_sel_i;
	logic [31:0] wb_dat_i, q; // q holds the last read
	wire logic [31:0] wb_dat_o;
	wire logic wb_ack_o, cpu_valid, cpu_rw, cpu_opfetch, bdc_access, cpu_break_force, cpu_break_tag;
	wire logic [15:0] cpu_addr, cpu_exec_addr, cof_src, cof_dst;
	wire logic [7:0] cpu_rdata, cpu_wdata;
	logic cpu_exec = 1'b0, cpu_flush = 1'b0, cof_valid = 1'b0; // side strobes
	logic [1:0] cof_kind = 2'h0;
	int mismatches = 0, comparisons = 0, i;
	bptd_unit uut (.ref_clk, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
		.wb_dat_i, .wb_dat_o, .wb_ack_o, .cpu_valid, .cpu_addr, .cpu_rw, .cpu_rdata,
		.cpu_wdata, .cpu_opfetch, .cpu_exec, .cpu_exec_addr, .cpu_flush, .bdc_access,
		.cof_valid, .cof_kind, .cof_src, .cof_dst, .cpu_break_force, .cpu_break_tag);
	bptd_cpu_model cpu (.ref_clk, .cpu_valid, .cpu_addr, .cpu_rw, .cpu_rdata, .cpu_wdata,
		.cpu_opfetch, .bdc_access, .cpu_exec_addr, .cof_src, .cof_dst);
	// 10 MHz clock
	initial begin
		ref_clk = 1'b0;
		forever #50 ref_clk = ~ref_clk;
	end
	// verdict and end of run
	task automatic end_of_test();
		$display("mismatches %0d comparisons %0d", mismatches, comparisons);
		if (mismatches == 0 && comparisons > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	// compare seen against expected
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			mismatches++;
			$display("mismatch at %0t: got %h want %h", $time, seen, exp);
		end
	endtask
	// one classic wishbone cycle, read data lands in q
	task automatic wb_xfer(input logic we, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge ref_clk);
		{wb_cyc_i, wb_stb_i, wb_we_i, wb_sel_i} <= {2'h3, we, 4'hF};
		wb_adr_i <= a;
		wb_dat_i <= d;
		do begin
			@(posedge ref_clk);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 20);
		q = wb_dat_o;
		{wb_cyc_i, wb_stb_i} <= 2'h0;
		if (n >= 20) begin
			$display("mismatch at %0t: no ack", $time);
			mismatches++;
			end_of_test();
		end
	endtask
	// bus read with exec and change-of-flow strobes beside it
	task automatic side_cycle(input logic [15:0] a, input logic ex, input logic cv,
		input logic [1:0] k);
		fork
			cpu.cycle(a, 1'b1, 8'h00, 1'b0, 1'b0);
			begin
				@(posedge ref_clk);
				{cpu_exec, cof_valid, cof_kind} <= {ex, cv, k};
				@(posedge ref_clk);
				{cpu_exec, cof_valid} <= 2'h0;
			end
		join
	endtask
	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		{rst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = 0;
		repeat (2) @(posedge ref_clk);
		rst_n <= 1'b1;
		wb_xfer(0, bptd_pkg::OFS_CTRL, 0);
		check(q, 32'h0);
		wb_xfer(1, 8'h40, 32'hFFFFFFFF);
		wb_xfer(0, 8'h40, 0);
		check(q, 32'h0);
		cpu.cycle(16'h0000, 1, 8'h00, 1, 0);
		#1 check(32'({cpu_break_force, cpu_break_tag}), 0);
		// forced breakpoint on any access
		wb_xfer(1, bptd_pkg::OFS_BKPT, 32'h1234);
		wb_xfer(1, bptd_pkg::OFS_CTRL, 32'h0003);
		for (i = 0; i < 3; i++) begin
			cpu.cycle(16'h1233 + 16'(i), 0, 8'h11, 0, 0);
			#1 check(32'({cpu_break_force, cpu_break_tag}), 32'(i == 1) << 1);
		end
		// tagged breakpoint on the fetched opcode, then none with the enable cleared
		wb_xfer(1, bptd_pkg::OFS_CTRL, 32'h0001);
		cpu.cycle(16'h1234, 1, 8'h22, 1, 0);
		#1 check(32'({cpu_break_force, cpu_break_tag}), 1);
		wb_xfer(1, bptd_pkg::OFS_CTRL, 32'h0000);
		cpu.cycle(16'h1234, 1, 8'h22, 1, 0);
		#1 check(32'({cpu_break_force, cpu_break_tag}), 0);
		// profiling while unarmed, first eight reads only fill
		for (i = 0; i < 8; i++) begin
			cpu.cycle(16'h2000 + 16'(i), 1, 8'h33, 1, 0);
			wb_xfer(0, bptd_pkg::OFS_FIFOL, 0);
			check(q, 32'h0);
		end
		wb_xfer(0, bptd_pkg::OFS_STAT, 0);
		check(q & 32'hF00, 32'h800);
		for (i = 0; i < 8; i++) begin
			cpu.cycle(16'h2100 + 16'(i), 1, 8'h44, 1, 0);
			wb_xfer(0, bptd_pkg::OFS_FIFOH, 0);
			check(q, 32'h20);
			wb_xfer(0, bptd_pkg::OFS_FIFOL, 0);
			check(q, 32'(i));
		end
		// event-only b stores data bytes, debug accesses blind
		wb_xfer(1, bptd_pkg::OFS_CMPB, 32'h3000);
		wb_xfer(1, bptd_pkg::OFS_CTRL, 32'h0304);
		cpu.cycle(16'h3000, 1, 8'h77, 0, 1);
		cpu.cycle(16'h3001, 1, 8'h66, 0, 0);
		for (i = 0; i < 8; i++) begin
			cpu.cycle(16'h3000, 1, 8'hA0 + 8'(i), 0, 0);
		end
		wb_xfer(0, bptd_pkg::OFS_STAT, 0);
		check(q & 32'hF01, 32'h800);
		for (i = 0; i < 8; i++) begin
			wb_xfer(0, bptd_pkg::OFS_FIFOL, 0);
			check(q, 32'hA0 + 32'(i));
		end
		// manual halt at three words, host skips stale words
		wb_xfer(1, bptd_pkg::OFS_CTRL, 32'h0304);
		for (i = 0; i < 3; i++) begin
			cpu.cycle(16'h3000, 1, 8'hC0 + 8'(i), 0, 0);
		end
		wb_xfer(1, bptd_pkg::OFS_CTRL, 32'h0000);
		wb_xfer(0, bptd_pkg::OFS_STAT, 0);
		check(q & 32'hF01, 32'h300);
		for (i = 0; i < 7; i++) begin
			wb_xfer(0, bptd_pkg::OFS_FIFOL, 0);
			if (i >= (8 - 3) - 1) begin
				check(q, 32'hC0 + 32'(i - 4));
			end
		end
		// opcode tracking: fetch alone never triggers, execution does
		wb_xfer(1, bptd_pkg::OFS_CMPA, 32'h5000);
		wb_xfer(1, bptd_pkg::OFS_CTRL, 32'h002C);
		cpu.cycle(16'h5000, 1, 8'h00, 1, 0);
		#1 check(32'(cpu_break_force), 0);
		side_cycle(16'h5000, 1, 0, bptd_pkg::COF_COND);
		#1 check(32'(cpu_break_force), 1);
		// end trace: branch source kept, unconditional dropped, trigger jump last
		wb_xfer(1, bptd_pkg::OFS_CTRL, 32'h0004);
		side_cycle(16'h6012, 0, 1, bptd_pkg::COF_COND);
		side_cycle(16'h6034, 0, 1, bptd_pkg::COF_UNCOND);
		side_cycle(16'h5000, 0, 1, bptd_pkg::COF_INDIR);
		repeat (2) @(posedge ref_clk);
		wb_xfer(0, bptd_pkg::OFS_STAT, 0);
		check(q & 32'hF01, 32'h200);
		for (i = 0; i < 7; i++) begin
			wb_xfer(0, bptd_pkg::OFS_FIFOL, 0);
		end
		check(q, 32'h12);
		wb_xfer(0, bptd_pkg::OFS_FIFOH, 0);
		check(q, 32'hAF);
		wb_xfer(0, bptd_pkg::OFS_FIFOL, 0);
		check(q, 32'hFF);
		// full mode on a qualified write uses the write data bus
		wb_xfer(1, bptd_pkg::OFS_CMPA, 32'h4000);
		wb_xfer(1, bptd_pkg::OFS_CMPB, 32'h0055);
		wb_xfer(1, bptd_pkg::OFS_CTRL, 32'h150C);
		cpu.cycle(16'h4000, 0, 8'h55, 0, 0);
		#1 check(32'(cpu_break_force), 0);
		cpu.cycle(16'h4000, 0, 8'hAA, 0, 0);
		#1 check(32'(cpu_break_force), 1);
		end_of_test();
	end
endmodule
